// file: common/gidc_pkg.sv
package gidc_pkg;

  // ****************************************************************
  // Control word layout
  // ****************************************************************
  localparam int unsigned CTRL_W        = 32;
  localparam int unsigned CLASS_N       = 4;
  localparam int unsigned BIT_FIXED     = 0;
  localparam int unsigned BIT_CLOCK     = 1;
  localparam int unsigned BIT_PROCESS   = 2;
  localparam int unsigned BIT_DELAY     = 3;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] RESERVED_MASK = 32'hffff_fff0;
  localparam logic [3:0]  TIME_CLASSES  = 4'hb;

  // ****************************************************************
  // Service call codes and answers
  // ****************************************************************
  localparam logic [15:0] FUNC_LOAD     = 16'h0001;
  localparam logic [15:0] FUNC_SET      = 16'h0002;
  localparam logic [15:0] FUNC_SET_INV  = 16'h0003;
  localparam logic [15:0] ERROR_CODE    = 16'h1a48;

  // ****************************************************************
  // Boundary selection and sequencer
  // ****************************************************************
  localparam logic        BOUNDARY_BLOCK = 1'b0;
  localparam logic        BOUNDARY_OPER  = 1'b1;

  typedef enum logic [2:0] {
    GIDC_IDLE  = 3'b001,
    GIDC_REPLY = 3'b010,
    GIDC_STOP  = 3'b100
  } gidc_fsm_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] func;
    logic [31:0] acc;
  } gidc_call_type;

  typedef struct packed {
    logic        done;
    logic        error;
    logic [31:0] acc;
  } gidc_reply_type;

  typedef struct packed {
    logic       block_boundary;
    logic       oper_boundary;
    logic       handler_busy;
    logic [3:0] request;
  } gidc_irq_in_type;

  typedef struct packed {
    gidc_fsm_type fsm;
    logic [31:0]  ctrl;
    logic [3:0]   pend;
    logic [31:0]  acc;
    logic         done;
    logic         error;
    logic         invoke;
    logic [3:0]   disp;
    logic [3:0]   coll;
  } gidc_state_type;

endpackage

// file: design/gidc_core.sv
`timescale 1ns/1ps

module gidc_core (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Service call from the processor
  input  wire gidc_pkg::gidc_call_type  delay_all_service_call,
  output      gidc_pkg::gidc_reply_type call_reply,
  // Runtime error handling
  input  wire logic                     handler_present,
  output      logic                     runtime_error_handler,
  output      logic                     stop_mode,
  // Interrupt sources and program boundaries
  input  wire gidc_pkg::gidc_irq_in_type irq_in,
  input  wire logic                     extended_config_block,
  output      logic [3:0]               dispatch,
  output      logic [3:0]               collision,
  // Status readback
  output      logic [31:0]              delay_status_system_word
);
  import gidc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  gidc_state_type state_reg;
  gidc_state_type state_next;

  logic [3:0]  delayed;
  logic        boundary;
  logic        func_ok;
  logic        call_err;
  logic [31:0] ctrl_new;
  logic        take;
  logic        call_err_q;

  // Reserved bits above the four class bits never count as delay
  function automatic logic [31:0] apply_call(input logic [15:0] func,
                                             input logic [31:0] word,
                                             input logic [31:0] mask);
    logic [31:0] res;
    res = word;
    case (func)
      FUNC_LOAD:    res = mask;
      FUNC_SET:     res = word | mask;
      FUNC_SET_INV: res = word | (~mask & ~RESERVED_MASK);
      default:      res = word;
    endcase
    return res;
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  always_comb begin
    delayed  = state_reg.ctrl[3:0];
    boundary = (extended_config_block == BOUNDARY_OPER) ? irq_in.oper_boundary
                                                        : irq_in.block_boundary;
    func_ok  = (delay_all_service_call.func == FUNC_LOAD) ||
               (delay_all_service_call.func == FUNC_SET) ||
               (delay_all_service_call.func == FUNC_SET_INV);
    call_err = !func_ok || ((delay_all_service_call.acc & RESERVED_MASK) != 32'h0000_0000);
    take     = delay_all_service_call.valid && (state_reg.fsm == GIDC_IDLE);
    ctrl_new = apply_call(delay_all_service_call.func, state_reg.ctrl,
                          delay_all_service_call.acc);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next        = state_reg;
    state_next.done   = 1'b0;
    state_next.error  = 1'b0;
    state_next.invoke = 1'b0;
    state_next.disp   = 4'h0;

    state_next.coll = irq_in.request & state_reg.pend & delayed & TIME_CLASSES;

    // Dispatch only when no handler is running, so an active one is not cut.
    // running handler not preempted
    if (boundary && !irq_in.handler_busy && state_reg.fsm != GIDC_STOP) begin
      state_next.disp = state_reg.pend & ~delayed;
    end

    // Set wins: a request in the dispatch cycle stays latched
    // keep latching while delayed
    state_next.pend = (state_reg.pend & ~state_next.disp) | irq_in.request;

    case (state_reg.fsm)
      GIDC_IDLE: begin
        if (take) begin
          state_next.fsm = GIDC_REPLY;
          if (call_err) begin
            state_next.acc = {delay_all_service_call.acc[31:16], ERROR_CODE};
          end else begin
            state_next.ctrl = ctrl_new;
            state_next.acc  = ctrl_new;
          end
        end
      end
      GIDC_REPLY: begin
        state_next.done  = 1'b1;
        state_next.error = call_err_q;
        if (call_err_q && !handler_present) begin
          state_next.fsm = GIDC_STOP;
        end else begin
          state_next.fsm    = GIDC_IDLE;
          state_next.invoke = call_err_q;
        end
      end
      GIDC_STOP: begin
        state_next.fsm = GIDC_STOP;
      end
      default: begin
        state_next.fsm = GIDC_IDLE;
      end
    endcase
  end

  // Error of the taken call, kept for the reply cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      call_err_q <= 1'b0;
    end else if (take) begin
      call_err_q <= call_err;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg.fsm    <= GIDC_IDLE;
      state_reg.ctrl   <= CTRL_RESET;
      state_reg.pend   <= 4'h0;
      state_reg.acc    <= 32'h0000_0000;
      state_reg.done   <= 1'b0;
      state_reg.error  <= 1'b0;
      state_reg.invoke <= 1'b0;
      state_reg.disp   <= 4'h0;
      state_reg.coll   <= 4'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign call_reply.done        = state_reg.done;
  assign call_reply.error       = state_reg.error;
  assign call_reply.acc         = state_reg.acc;
  assign runtime_error_handler  = state_reg.invoke;
  assign stop_mode              = (state_reg.fsm == GIDC_STOP);
  assign dispatch               = state_reg.disp;
  assign collision              = state_reg.coll;
  assign delay_status_system_word = state_reg.ctrl;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_delayed_not_sent: assert property (
    (dispatch & $past(state_reg.ctrl[3:0])) == 4'h0)
    else $error("delayed class dispatched");

  chk_fixed_held: assert property (
    state_reg.ctrl[BIT_FIXED] |=> !dispatch[BIT_FIXED])
    else $error("fixed interval dispatched while delayed");

  chk_process_held: assert property (
    state_reg.ctrl[BIT_PROCESS] |=> !dispatch[BIT_PROCESS])
    else $error("process interrupt dispatched while delayed");

  chk_release_sent: assert property (
    (boundary && !irq_in.handler_busy && !stop_mode && state_reg.pend[0] && !delayed[0])
      |=> dispatch[0])
    else $error("released interrupt not dispatched");

  chk_pending_kept: assert property (
    (state_reg.pend[2] && delayed[2]) |=> state_reg.pend[2])
    else $error("pending interrupt lost while delayed");

  chk_busy_no_send: assert property (
    irq_in.handler_busy |=> dispatch == 4'h0)
    else $error("dispatch while handler running");

  chk_bad_code_err: assert property (
    (take && !func_ok) |-> ##2 (call_reply.done && call_reply.error))
    else $error("illegal code not reported");

  chk_error_code: assert property (
    (call_reply.done && call_reply.error) |-> call_reply.acc[15:0] == ERROR_CODE)
    else $error("wrong error code");

  chk_reserved_err: assert property (
    (take && delay_all_service_call.acc[31:4] != 28'h0) |=> ##1 call_reply.error)
    else $error("reserved bits accepted");

  chk_load_echo: assert property (
    (take && !call_err && delay_all_service_call.func == FUNC_LOAD)
      |=> delay_status_system_word == $past(delay_all_service_call.acc)
          ##1 call_reply.acc == delay_status_system_word)
    else $error("load not echoed");

  chk_collision_flag: assert property (
    (irq_in.request[BIT_CLOCK] && state_reg.pend[BIT_CLOCK] && delayed[BIT_CLOCK])
      |=> collision[BIT_CLOCK])
    else $error("collision not flagged");

  chk_stop_no_handler: assert property (
    (call_reply.done && call_reply.error && !$past(handler_present)) |-> stop_mode)
    else $error("stop not entered");

  chk_clock_held: assert property (
    state_reg.ctrl[BIT_CLOCK] |=> !dispatch[BIT_CLOCK])
    else $error("clock-driven interrupt dispatched while delayed");

  chk_delay_irq_held: assert property (
    state_reg.ctrl[BIT_DELAY] |=> !dispatch[BIT_DELAY])
    else $error("delay interrupt dispatched while delayed");

  chk_reserved_keeps: assert property (
    (take && call_err) |=> $stable(delay_status_system_word))
    else $error("failed call changed the control word");

  chk_pending_fixed: assert property (
    (state_reg.pend[BIT_FIXED] && delayed[BIT_FIXED]) |=> state_reg.pend[BIT_FIXED])
    else $error("pending fixed interval lost while delayed");

  chk_pending_clock: assert property (
    (state_reg.pend[BIT_CLOCK] && delayed[BIT_CLOCK]) |=> state_reg.pend[BIT_CLOCK])
    else $error("pending clock interrupt lost while delayed");

  chk_pending_delay: assert property (
    (state_reg.pend[BIT_DELAY] && delayed[BIT_DELAY]) |=> state_reg.pend[BIT_DELAY])
    else $error("pending delay interrupt lost while delayed");

  chk_request_latched: assert property (
    irq_in.request[BIT_PROCESS] |=> state_reg.pend[BIT_PROCESS])
    else $error("process request not latched");

  chk_busy_keeps: assert property (
    (irq_in.handler_busy && state_reg.pend[BIT_FIXED]) |=> state_reg.pend[BIT_FIXED])
    else $error("pending interrupt lost while handler running");

  chk_release_process: assert property (
    (boundary && !irq_in.handler_busy && !stop_mode && state_reg.pend[BIT_PROCESS] &&
     !delayed[BIT_PROCESS]) |=> dispatch[BIT_PROCESS])
    else $error("released process interrupt not dispatched");

  chk_dispatch_clears: assert property (
    dispatch[BIT_FIXED] |-> (!state_reg.pend[BIT_FIXED] || $past(irq_in.request[BIT_FIXED])))
    else $error("dispatched interrupt left pending");

  chk_collision_fixed: assert property (
    (irq_in.request[BIT_FIXED] && state_reg.pend[BIT_FIXED] && delayed[BIT_FIXED])
      |=> collision[BIT_FIXED])
    else $error("fixed interval collision not flagged");

  chk_collision_delay: assert property (
    (irq_in.request[BIT_DELAY] && state_reg.pend[BIT_DELAY] && delayed[BIT_DELAY])
      |=> collision[BIT_DELAY])
    else $error("delay interrupt collision not flagged");

  chk_reply_timing: assert property (
    take |-> ##2 call_reply.done)
    else $error("call not answered in two cycles");

  chk_good_no_error: assert property (
    (take && !call_err) |-> ##2 !call_reply.error)
    else $error("legal call reported as error");

  chk_reply_word: assert property (
    (take && !call_err) |-> ##2 (call_reply.acc == delay_status_system_word))
    else $error("reply does not carry the control word");

  chk_set_mask: assert property (
    (take && !call_err && delay_all_service_call.func == FUNC_SET)
      |=> delay_status_system_word ==
          ($past(state_reg.ctrl) | $past(delay_all_service_call.acc)))
    else $error("set by mask wrong");

  chk_set_inverse: assert property (
    (take && !call_err && delay_all_service_call.func == FUNC_SET_INV)
      |=> delay_status_system_word ==
          ($past(state_reg.ctrl) | {28'h0000000, ~$past(delay_all_service_call.acc[3:0])}))
    else $error("set by inverted mask wrong");

  chk_handler_pulse: assert property (
    (call_reply.done && call_reply.error && $past(handler_present)) |-> runtime_error_handler)
    else $error("runtime error handler not invoked");

  chk_stop_stays: assert property (
    stop_mode |=> stop_mode)
    else $error("stop left without reset");

  chk_stop_no_send: assert property (
    stop_mode |=> dispatch == 4'h0)
    else $error("dispatch while stopped");

  chk_status_steady: assert property (
    !take |=> $stable(delay_status_system_word))
    else $error("status word changed without a call");

  chk_block_select: assert property (
    (extended_config_block == BOUNDARY_BLOCK && !irq_in.block_boundary) |=> dispatch == 4'h0)
    else $error("dispatch without block boundary");

  chk_oper_select: assert property (
    (extended_config_block == BOUNDARY_OPER && !irq_in.oper_boundary) |=> dispatch == 4'h0)
    else $error("dispatch without operation boundary");

  chk_reset_clear: assert property (
    $fell(rst) |-> (delay_status_system_word == CTRL_RESET && state_reg.pend == 4'h0 &&
                    !stop_mode && !call_reply.done))
    else $error("state not cleared by reset");

endmodule // gidc_core

// file: testbench/global_interrupt_delay_control_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end

module global_interrupt_delay_control_test;
  import gidc_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic            sys_clk;
  logic            rst;
  logic            handler_present;
  logic            extended_config_block;
  gidc_call_type   call;
  gidc_reply_type  call_reply;
  gidc_irq_in_type irq_in;
  logic            runtime_error_handler;
  logic            stop_mode;
  logic [3:0]      dispatch;
  logic [3:0]      collision;
  logic [3:0]      disp_seen;
  logic [3:0]      coll_seen;
  logic [31:0]     delay_status_system_word;
  logic [31:0]     lfsr_reg;
  logic [31:0]     ctrl_m;
  int              fails;
  int              n_checks;

  gidc_core u_gidc_core (
    .sys_clk                  (sys_clk),
    .rst                      (rst),
    .delay_all_service_call   (call),
    .call_reply               (call_reply),
    .handler_present          (handler_present),
    .runtime_error_handler    (runtime_error_handler),
    .stop_mode                (stop_mode),
    .irq_in                   (irq_in),
    .extended_config_block    (extended_config_block),
    .dispatch                 (dispatch),
    .collision                (collision),
    .delay_status_system_word (delay_status_system_word)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // ****************************************************************
  // Service call with model update
  // ****************************************************************
  task automatic do_call(input logic [15:0] fn, input logic [31:0] a);
    logic        err;
    logic [31:0] exp_acc;
    int          k;
    err = (fn < 16'h0001) || (fn > 16'h0003) || (a[31:4] != 28'h0);
    if (!err) begin
      case (fn)
        16'h0001: ctrl_m = a;
        16'h0002: ctrl_m = ctrl_m | a;
        default:  ctrl_m = ctrl_m | {28'h0, ~a[3:0]};
      endcase
    end
    exp_acc = err ? {a[31:16], 16'h1a48} : ctrl_m;
    @(posedge sys_clk);
    call <= '{valid: 1'b1, func: fn, acc: a};
    @(posedge sys_clk);
    call.valid <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (call_reply.done !== 1'b1 && k < 6);
    `CHK("done", 1'b1, call_reply.done)
    `CHK("error", err, call_reply.error)
    `CHK("acc", exp_acc, call_reply.acc)
    `CHK("handler", err & handler_present, runtime_error_handler)
    `CHK("stop", err & ~handler_present, stop_mode)
    `CHK("status", ctrl_m, delay_status_system_word)
  endtask

  // One input pulse, then dispatch and collision gathered over three cycles
  task automatic pulse(input logic [3:0] req, input logic bb, input logic ob);
    @(posedge sys_clk);
    irq_in.request        <= req;
    irq_in.block_boundary <= bb;
    irq_in.oper_boundary  <= ob;
    @(posedge sys_clk);
    irq_in.request        <= 4'h0;
    irq_in.block_boundary <= 1'b0;
    irq_in.oper_boundary  <= 1'b0;
    disp_seen = 4'h0;
    coll_seen = 4'h0;
    repeat (3) begin
      #1;
      disp_seen = disp_seen | dispatch;
      coll_seen = coll_seen | collision;
      @(posedge sys_clk);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    report_and_stop;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    handler_present = 1'b1;
    extended_config_block = 1'b0;
    call = '0;
    irq_in = '0;
    lfsr_reg = 32'h21a7afa8;
    ctrl_m = 32'h0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("reset word", 32'h0, delay_status_system_word)
    do_call(16'h0004, 32'h0);
    do_call(16'hffff, 32'h0);
    do_call(16'h0002, 32'h10);
    do_call(16'h0002, 32'h0);
    do_call(16'h0003, 32'h0);
    for (int i = 0; i < 16; i++) begin
      lfsr_reg = lfsr_step(lfsr_reg);
      do_call({14'h0, lfsr_reg[1:0]}, lfsr_reg[5] ? lfsr_reg : {28'h0, lfsr_reg[11:8]});
    end
    $display("test calls done");
    for (int c = 0; c < 4; c++) begin
      do_call(16'h0001, 32'h1 << c);
      pulse(4'hf, 1'b0, 1'b0);
      pulse(4'h1 << c, 1'b0, 1'b0);
      `CHK("collision", (c == 2) ? 4'h0 : (4'h1 << c), coll_seen)
      pulse(4'h0, 1'b1, 1'b0);
      `CHK("held", 4'hf & ~(4'h1 << c), disp_seen)
      do_call(16'h0002, 32'h0);
      do_call(16'h0001, 32'h0);
      pulse(4'h0, 1'b1, 1'b0);
      `CHK("released", 4'h1 << c, disp_seen)
    end
    $display("test classes done");
    extended_config_block <= 1'b1;
    pulse(4'h4, 1'b0, 1'b0);
    pulse(4'h0, 1'b1, 1'b0);
    `CHK("block boundary", 4'h0, disp_seen)
    pulse(4'h0, 1'b0, 1'b1);
    `CHK("oper boundary", 4'h4, disp_seen)
    extended_config_block <= 1'b0;
    pulse(4'h1, 1'b0, 1'b0);
    pulse(4'h0, 1'b0, 1'b1);
    `CHK("oper ignored", 4'h0, disp_seen)
    irq_in.handler_busy <= 1'b1;
    pulse(4'h0, 1'b1, 1'b0);
    `CHK("busy", 4'h0, disp_seen)
    irq_in.handler_busy <= 1'b0;
    pulse(4'h0, 1'b1, 1'b0);
    `CHK("after busy", 4'h1, disp_seen)
    $display("test boundaries done");
    handler_present <= 1'b0;
    do_call(16'h0000, 32'h5);
    @(posedge sys_clk);
    call <= '{valid: 1'b1, func: 16'h0001, acc: 32'h0000_0003};
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("stop kept", 1'b1, stop_mode)
    `CHK("stop word", ctrl_m, delay_status_system_word)
    `CHK("stop no answer", 1'b0, call_reply.done)
    $display("test stop done");
    report_and_stop;
  end

endmodule // global_interrupt_delay_control_test
